/* File: common/bimf_pkg.sv */
// Shared constants and types for the burst instruction memory controller
package bimf_pkg;
    localparam int unsigned BIMF_ADDR_W     = 32;
    localparam int unsigned BIMF_CNT_W      = 8;
    localparam int unsigned BIMF_DATA_W     = 32;
    localparam int unsigned BIMF_FIFO_DEPTH = 8;
    localparam int unsigned BIMF_MEM_WORDS  = 256;
    localparam logic [BIMF_ADDR_W-1:0] BIMF_DECODE_MASK = 32'hFFFF_FC00;
    localparam logic [BIMF_ADDR_W-1:0] BIMF_DECODE_BASE = 32'h0000_0000;
    localparam logic [BIMF_CNT_W-1:0]  BIMF_CNT_ONE     = 8'h01;
    localparam logic [BIMF_CNT_W-1:0]  BIMF_CNT_ZERO    = 8'h00;
    localparam logic [BIMF_ADDR_W-1:0] BIMF_ADDR_ZERO   = 32'h0000_0000;
    localparam logic [BIMF_DATA_W-1:0] BIMF_DATA_ZERO   = 32'h0000_0000;
    localparam logic [BIMF_ADDR_W-1:0] BIMF_ADDR_STEP   = 32'h0000_0004;
    localparam logic                   BIMF_SPACE_ID    = 1'b0;
    typedef enum logic [1:0] {
        BIMF_IDLE,
        BIMF_START,
        BIMF_BURST
    } bimf_state_e;
endpackage

/* File: common/bimf_if.sv */
// Instruction bus between processor prefetcher and memory controller
`timescale 1ns/1ps
interface bimf_if
    import bimf_pkg::*;
();
    logic                   instr_req;
    logic                   burst_req;
    logic                   req_type;
    logic                   bus_invalid;
    logic [BIMF_ADDR_W-1:0] addr;
    logic                   instr_ready;
    logic                   burst_acknowledge;
    logic [BIMF_DATA_W-1:0] instr;

    modport mem (
        input  instr_req,
        input  burst_req,
        input  req_type,
        input  bus_invalid,
        input  addr,
        output instr_ready,
        output burst_acknowledge,
        output instr
    );
    modport cpu (
        output instr_req,
        output burst_req,
        output req_type,
        output bus_invalid,
        output addr,
        input  instr_ready,
        input  burst_acknowledge,
        input  instr
    );
endinterface

/* File: rtl/bimf_fifo.sv */
// Parameterised valid/ready FIFO for the fetched instruction stream
`timescale 1ns/1ps
module bimf_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Handshakes from occupancy
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // Storage array, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: rtl/bimf_mem_ctrl.sv */
// Memory-end controller: burst state machine, address latch/counter and SRAM
`timescale 1ns/1ps
module bimf_mem_ctrl
    import bimf_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   nrst,
    bimf_if.mem                         bus,
    input  wire logic                   wr_en,
    input  wire logic [BIMF_CNT_W-1:0]  wr_index,
    input  wire logic [BIMF_DATA_W-1:0] wr_data,
    output logic                        addr_load_strobe,
    output logic                        addr_increment,
    output logic                        busy
);
    typedef struct packed {
        bimf_state_e            state;
        logic                   burst_req_d1;
        logic [BIMF_ADDR_W-1:0] base;
        logic [BIMF_CNT_W-1:0]  count;
        logic [BIMF_DATA_W-1:0] instr;
    } bimf_regs_s;

    bimf_regs_s regs_q;
    bimf_regs_s regs_d;

    logic [BIMF_DATA_W-1:0] sram_q [BIMF_MEM_WORDS];
    logic                   instr_mem_access_cond;
    logic                   decode_hit;
    logic [BIMF_CNT_W-1:0]  rd_index;
    logic                   start_ok;

    localparam int unsigned WORD_LSB = 2;
    localparam int unsigned WORD_MSB = BIMF_CNT_W + WORD_LSB - 1;

    // Access condition from decode, space type, validity and request
    assign decode_hit            = ((bus.addr & BIMF_DECODE_MASK) == BIMF_DECODE_BASE);
    assign instr_mem_access_cond = decode_hit && (bus.req_type == BIMF_SPACE_ID)
                                   && !bus.bus_invalid && bus.instr_req;

    // Acknowledge on start with burst, and in burst until a new request; stays on while suspended
    assign bus.burst_acknowledge = (regs_q.burst_req_d1 && (regs_q.state == BIMF_START))
                                   || ((regs_q.state == BIMF_BURST) && !bus.instr_req);
    assign addr_increment = bus.burst_acknowledge && regs_q.burst_req_d1;
    assign addr_load_strobe = instr_mem_access_cond
                              && ((regs_q.state == BIMF_IDLE) || (regs_q.state == BIMF_BURST));
    assign start_ok = (regs_q.state == BIMF_START);

    // Ready: simple completion in start, or each non-suspended burst cycle
    assign bus.instr_ready = start_ok || addr_increment;
    assign bus.instr       = regs_q.instr;
    assign busy            = (regs_q.state != BIMF_IDLE);

    // Word fetched ahead: new address on load, else latch plus counter plus one
    assign rd_index = addr_load_strobe ? bus.addr[WORD_MSB:WORD_LSB]
                      : (regs_q.base[WORD_MSB:WORD_LSB] + regs_q.count + BIMF_CNT_ONE);

    // Next-state and datapath
    always_comb begin
        regs_d              = regs_q;
        regs_d.burst_req_d1 = bus.burst_req;
        case (regs_q.state)
            BIMF_IDLE: begin
                if (instr_mem_access_cond) begin
                    regs_d.state = BIMF_START;
                end
            end
            BIMF_START: begin
                if (regs_q.burst_req_d1) begin
                    regs_d.state = BIMF_BURST;
                end else begin
                    regs_d.state = BIMF_IDLE;
                end
            end
            BIMF_BURST: begin
                if (instr_mem_access_cond) begin
                    regs_d.state = BIMF_START;
                end else if (bus.instr_req && !regs_q.burst_req_d1) begin
                    regs_d.state = BIMF_IDLE;
                end else begin
                    regs_d.state = BIMF_BURST;
                end
            end
            default: begin
                regs_d.state = BIMF_IDLE;
            end
        endcase
        if (addr_load_strobe) begin
            regs_d.base  = bus.addr;
            regs_d.count = BIMF_CNT_ZERO;
        end else if (addr_increment) begin
            regs_d.count = regs_q.count + BIMF_CNT_ONE;
        end
        // Word register is filled ahead so it stands valid in the ready cycle
        if (addr_load_strobe || addr_increment) begin
            regs_d.instr = sram_q[rd_index];
        end
    end

    // Instruction SRAM, loaded from the user side
    always_ff @(posedge clk) begin
        if (wr_en) begin
            sram_q[wr_index] <= wr_data;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regs_q.state        <= BIMF_IDLE;
            regs_q.burst_req_d1 <= 1'b0;
            regs_q.base         <= BIMF_ADDR_ZERO;
            regs_q.count        <= BIMF_CNT_ZERO;
            regs_q.instr        <= BIMF_DATA_ZERO;
        end else begin
            regs_q <= regs_d;
        end
    end
endmodule

/* File: rtl/bimf_cpu_fetch.sv */
// Processor-end fetch unit: issues requests, bursts, buffers the stream
`timescale 1ns/1ps
module bimf_cpu_fetch
    import bimf_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   nrst,
    bimf_if.cpu                         bus,
    input  wire logic                   fetch_go,
    input  wire logic [BIMF_ADDR_W-1:0] fetch_addr,
    input  wire logic                   fetch_burst,
    input  wire logic                   fetch_invalid,
    output logic                        instr_valid,
    input  wire logic                   instr_taken,
    output logic [BIMF_DATA_W-1:0]      instr_data,
    output logic                        fetch_busy
);
    typedef struct packed {
        logic                   req;
        logic                   burst;
        logic [BIMF_ADDR_W-1:0] addr;
        logic [3:0]             level;
    } bimf_cpu_s;

    localparam logic [3:0] LVL_LAST = 4'(BIMF_FIFO_DEPTH - 1);
    localparam logic [3:0] LVL_ONE  = 4'h1;

    bimf_cpu_s cpu_q;
    bimf_cpu_s cpu_d;
    logic      fifo_ready;
    logic      fifo_in_valid;
    logic      pop;
    logic      room;

    // Room for the word already in flight plus one more
    assign pop  = instr_valid && instr_taken;
    assign room = (cpu_q.level < LVL_LAST) || ((cpu_q.level == LVL_LAST) && !bus.instr_ready);

    // Bus drive; burst request held only while buffer has room
    assign bus.instr_req   = cpu_q.req;
    assign bus.addr        = cpu_q.addr;
    assign bus.req_type    = BIMF_SPACE_ID;
    assign bus.bus_invalid = fetch_invalid;
    assign bus.burst_req   = cpu_q.burst && room;
    assign fifo_in_valid   = bus.instr_ready;
    assign fetch_busy      = cpu_q.req || cpu_q.burst;

    // Request sequencing
    always_comb begin
        cpu_d = cpu_q;
        if (fetch_go && fifo_ready) begin
            cpu_d.req   = 1'b1;
            cpu_d.addr  = fetch_addr;
            cpu_d.burst = fetch_burst;
        end else if (bus.burst_acknowledge) begin
            cpu_d.req  = 1'b0;
            cpu_d.addr = BIMF_ADDR_ZERO;
        end else if (bus.instr_ready && !cpu_q.burst) begin
            cpu_d.req = 1'b0;
        end else if (fetch_invalid) begin
            cpu_d.req = 1'b0; // Cancelled request withdrawn
        end
        // Buffer occupancy as seen by the burst throttle
        if (bus.instr_ready && !pop) begin
            cpu_d.level = cpu_q.level + LVL_ONE;
        end else if (!bus.instr_ready && pop) begin
            cpu_d.level = cpu_q.level - LVL_ONE;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_q.req   <= 1'b0;
            cpu_q.burst <= 1'b0;
            cpu_q.addr  <= BIMF_ADDR_ZERO;
            cpu_q.level <= 4'h0;
        end else begin
            cpu_q <= cpu_d;
        end
    end

    // Prefetch buffer for delivered instructions
    bimf_fifo #(
        .WIDTH (BIMF_DATA_W),
        .DEPTH (BIMF_FIFO_DEPTH)
    ) u_prefetch (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_ready),
        .in_data   (bus.instr),
        .out_valid (instr_valid),
        .out_ready (instr_taken),
        .out_data  (instr_data)
    );
endmodule

/* File: test/bimf_monitor.sv */
// Assertion checker on the instruction bus joining both ends
`timescale 1ns/1ps
module bimf_monitor
    import bimf_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   nrst,
    input wire logic                   instr_req,
    input wire logic                   burst_req,
    input wire logic                   req_type,
    input wire logic                   bus_invalid,
    input wire logic [BIMF_ADDR_W-1:0] addr,
    input wire logic                   instr_ready,
    input wire logic                   burst_acknowledge,
    input wire logic [BIMF_DATA_W-1:0] instr
);
    logic breq_q;
    logic acc;
    logic take;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Registered copy of the burst request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            breq_q <= 1'b0;
        end else begin
            breq_q <= burst_req;
        end
    end
    // Access condition; a take is the condition outside a ready cycle
    assign acc  = ((addr & BIMF_DECODE_MASK) == BIMF_DECODE_BASE) && (req_type == BIMF_SPACE_ID)
                  && !bus_invalid && instr_req;
    assign take = acc && !instr_ready;
    ack_from_copy_a: assert property ($rose(burst_acknowledge) |-> breq_q)
        else $error("acknowledge raised without registered burst request");
    take_then_ready_a: assert property (take |=> instr_ready)
        else $error("no ready in cycle after access");
    take_no_ack_a: assert property (take |-> !burst_acknowledge)
        else $error("acknowledge during new access");
    invalid_ignored_a: assert property ((instr_req && bus_invalid && !burst_req && !breq_q && !instr_ready)
        |=> !instr_ready)
        else $error("cancelled access answered");
    run_needs_burst_a: assert property ((instr_ready && $past(instr_ready)) |-> breq_q && burst_acknowledge)
        else $error("back-to-back ready outside burst");
    ack_gives_ready_a: assert property ((burst_acknowledge && breq_q) |-> instr_ready)
        else $error("running burst without ready");
    suspend_no_ready_a: assert property ((burst_acknowledge && !breq_q) |-> !instr_ready)
        else $error("ready during suspended burst");
    word_holds_a: assert property ((!instr_ready && !$past(instr_ready)) |-> $stable(instr))
        else $error("word changed without ready");
    burst_goes_on_a: assert property ((burst_acknowledge && burst_req && !instr_req)
        |=> (burst_acknowledge || instr_req))
        else $error("burst dropped while requested");
    cover property (take ##1 instr_ready);
    cover property (burst_acknowledge [*4]);
    cover property ((burst_acknowledge && !instr_ready) ##1 (burst_acknowledge && instr_ready));
endmodule

/* File: test/tb.sv */
// Self-checking bench joining the processor end and the memory end
`timescale 1ns/1ps
module tb
    import bimf_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        wr_en = 1'b0;
    logic [7:0]  wr_index = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        fetch_go = 1'b0;
    logic [31:0] fetch_addr = 32'h0;
    logic        fetch_burst = 1'b0;
    logic        fetch_invalid = 1'b0;
    logic        instr_taken = 1'b1;
    logic        instr_valid;
    logic [31:0] instr_data;
    logic        inc;
    logic [31:0] mem [256];
    logic [7:0]  idx_q [$];
    logic [31:0] fq [$];
    logic [7:0]  ptr;
    int          errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    bimf_if bimf_if_i ();
    bimf_mem_ctrl bimf_mem_ctrl_i (.clk(clk), .nrst(nrst), .bus(bimf_if_i), .wr_en(wr_en), .wr_index(wr_index),
        .wr_data(wr_data), .addr_load_strobe(), .addr_increment(inc), .busy());
    bimf_cpu_fetch bimf_cpu_fetch_i (.clk(clk), .nrst(nrst), .bus(bimf_if_i), .fetch_go(fetch_go),
        .fetch_addr(fetch_addr), .fetch_burst(fetch_burst), .fetch_invalid(fetch_invalid),
        .instr_valid(instr_valid), .instr_taken(instr_taken), .instr_data(instr_data), .fetch_busy());
    bimf_monitor bimf_monitor_i (.clk(clk), .nrst(nrst), .instr_req(bimf_if_i.instr_req),
        .burst_req(bimf_if_i.burst_req), .req_type(bimf_if_i.req_type), .bus_invalid(bimf_if_i.bus_invalid),
        .addr(bimf_if_i.addr), .instr_ready(bimf_if_i.instr_ready),
        .burst_acknowledge(bimf_if_i.burst_acknowledge), .instr(bimf_if_i.instr));
    // Clock
    always #4 clk = ~clk;
    // Compare one value
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            finish_test();
        end
    end
    // Observer: words out of the buffer, then words on the bus
    always @(posedge clk) begin
        if (nrst && instr_valid && instr_taken) begin
            if (fq.size() == 0) check("spare word", 32'h1, 32'h0);
            else check("fifo word", instr_data, fq.pop_front());
        end
        if (nrst && bimf_if_i.instr_ready) begin
            if (bimf_if_i.instr_req) begin
                if (idx_q.size() == 0) check("spare access", 32'h1, 32'h0);
                else ptr = idx_q.pop_front();
            end else begin
                ptr = ptr + 8'h01;
                check("increment", {31'h0, inc}, 32'h1);
            end
            check("bus word", bimf_if_i.instr, mem[ptr]);
            fq.push_back(mem[ptr]);
        end
        if (nrst && bimf_if_i.burst_acknowledge && !bimf_if_i.instr_ready) begin
            check("suspend increment", {31'h0, inc}, 32'h0);
        end
    end
    // One fetch request, noted unless cancelled
    task automatic go(input logic [7:0] idx, input logic inv);
        fetch_addr <= {22'h0, idx, 2'b00};
        fetch_invalid <= inv;
        fetch_go <= 1'b1;
        if (!inv) idx_q.push_back(idx);
        @(posedge clk);
        fetch_go <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // Main sequence
    initial begin
        void'($urandom(99746));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            mem[i] = $urandom;
            wr_en <= 1'b1;
            wr_index <= i[7:0];
            wr_data <= mem[i];
        end
        @(posedge clk);
        wr_en <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            instr_taken <= 1'($urandom);
            go(8'($urandom), 1'b0);
        end
        instr_taken <= 1'b1;
        go(8'h10, 1'b1);
        instr_taken <= 1'b0;
        fetch_burst <= 1'b1;
        go(8'hFC, 1'b0);
        repeat (20) @(posedge clk);
        instr_taken <= 1'b1;
        repeat (10) @(posedge clk);
        instr_taken <= 1'b0;
        repeat (15) @(posedge clk);
        instr_taken <= 1'b1;
        repeat (6) @(posedge clk);
        fetch_burst <= 1'b0;
        go(8'h40, 1'b0);
        repeat (30) @(posedge clk);
        check("pending", idx_q.size(), 32'h0);
        check("leftover", fq.size(), 32'h0);
        finish_test();
    end
endmodule
